/* File: rtl/eeprom_mem.v */
// single-port byte memory with registered read data
`timescale 1ns/1ps
module eeprom_mem #(
	parameter AW = 11,
	parameter DW = 8
) (
	input  wire          clk,
	input  wire          rstn,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata_q
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// array contents have no reset, as in a real cell array
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			rdata_q <= {DW{1'b0}};
		end else begin
			rdata_q <= mem[addr];
		end
	end
endmodule

/* File: rtl/eeprom_slave.v */
// two-wire serial memory slave: protocol engine, page buffer, write cycle, read prefetch
`timescale 1ns/1ps
`include "eeprom_slave_regs.vh"
module eeprom_slave #(
	parameter [3:0] DEV_TYPE     = 4'h5,
	parameter       WRITE_CYCLES = `T_WR_US * `MCLK_KHZ / 1000,
	parameter       TW           = 17
) (
	input  wire MCLK,
	input  wire RSTN,
	input  wire SCL,
	input  wire SDA_I,
	output wire SDA_O,
	output reg  SDA_OE_N,
	output reg  BUSY
);
	// DEV_TYPE default is arbitrary
	localparam [TW-1:0] WC_LAST = WRITE_CYCLES - 1;

	// pin synchronisers; first stage is read only by the second
	reg scl_m_q;
	reg scl_s_q;
	reg scl_d_q;
	reg sda_m_q;
	reg sda_s_q;
	reg sda_d_q;

	always @(posedge MCLK) begin
		if (!RSTN) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_d_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_m_q <= SCL;
			scl_s_q <= scl_m_q;
			scl_d_q <= scl_s_q;
			sda_m_q <= SDA_I;
			sda_s_q <= sda_m_q;
			sda_d_q <= sda_s_q;
		end
	end

	wire scl_rise = scl_s_q & ~scl_d_q;
	wire scl_fall = ~scl_s_q & scl_d_q;
	// a data edge with clock high is never data, only start or stop
	wire start_c  = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
	wire stop_c   = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

	// open drain: only ever pulls low
	assign SDA_O = 1'b0;

	reg [2:0]              st_q;
	reg [2:0]              nxt_q;
	reg [3:0]              cnt_q;
	reg [`BYTE_W-1:0]      sr_q;
	reg [`BYTE_W-1:0]      tx_q;
	reg [`ARR_AW-1:0]      addr_q;
	reg [2:0]              bank_q;
	reg                    rmode_q;
	reg                    mack_q;
	reg                    flush_q;
	reg                    wstart_q;
	reg [(1<<`PAGE_AW)-1:0] mask_q;
	reg                    pwe_q;
	reg [`PAGE_AW-1:0]     pwa_q;
	reg [`BYTE_W-1:0]      pwd_q;

	// two-entry read buffer between array and shifter
	reg [`BYTE_W-1:0]      f0_q;
	reg [`BYTE_W-1:0]      f1_q;
	reg [1:0]              fcnt_q;
	reg                    infl_q;
	reg [`ARR_AW-1:0]      pf_q;

	// write cycle
	reg [TW-1:0]           tmr_q;
	reg [4:0]              cidx_q;
	reg [`PAGE_AW-1:0]     cidx_d_q;
	reg                    cv_q;
	reg [(1<<`PAGE_AW)-1:0] wmask_q;

	wire [`BYTE_W-1:0] page_rd;
	wire [`BYTE_W-1:0] arr_rd;

	wire out_valid = (fcnt_q != 2'h0);
	wire pop_c     = out_valid & scl_fall & ~start_c & ~stop_c &
	                 (((st_q == `ST_ACK) & (nxt_q == `ST_TX)) |
	                  ((st_q == `ST_RACK) & mack_q));
	wire [`BYTE_W-1:0] out_data = out_valid ? f0_q : 8'hFF;
	wire [2:0] used    = {1'b0, fcnt_q} + {2'h0, infl_q};
	// buffer ready: fetching stalls while two entries are held or in flight
	wire in_ready      = (used < 3'h2);
	wire fetch_c       = rmode_q & ~flush_q & ~BUSY & in_ready;
	wire load_c        = (st_q == `ST_ACK) ? (nxt_q == `ST_TX) : mack_q;

	// protocol engine
	always @(posedge MCLK) begin
		if (!RSTN) begin
			st_q     <= `ST_IDLE;
			nxt_q    <= `ST_IDLE;
			cnt_q    <= 4'h0;
			sr_q     <= 8'h00;
			tx_q     <= 8'h00;
			addr_q   <= 11'h000;
			bank_q   <= 3'h0;
			rmode_q  <= 1'b0;
			mack_q   <= 1'b0;
			flush_q  <= 1'b0;
			wstart_q <= 1'b0;
			mask_q   <= 16'h0000;
			pwe_q    <= 1'b0;
			pwa_q    <= 4'h0;
			pwd_q    <= 8'h00;
			SDA_OE_N <= 1'b1;
		end else begin
			flush_q  <= 1'b0;
			wstart_q <= 1'b0;
			pwe_q    <= 1'b0;
			// the write cycle copies the mask one edge after the stop, so clear it only then
			if (wstart_q) begin
				mask_q <= 16'h0000;
			end
			if (start_c) begin
				// a repeated start drops uncommitted data
				st_q     <= `ST_DEV;
				cnt_q    <= 4'h0;
				mask_q   <= 16'h0000;
				rmode_q  <= 1'b0;
				SDA_OE_N <= 1'b1;
			end else if (stop_c) begin
				st_q     <= `ST_IDLE;
				rmode_q  <= 1'b0;
				SDA_OE_N <= 1'b1;
				if (mask_q != 16'h0000 && !BUSY) begin
					wstart_q <= 1'b1;
				end
			end else begin
				case (st_q)
				`ST_DEV, `ST_WORD, `ST_DATA: begin
					if (scl_rise) begin
						sr_q  <= {sr_q[6:0], sda_s_q};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `BYTE_BITS) begin
						cnt_q <= 4'h0;
						st_q  <= `ST_ACK;
						SDA_OE_N <= 1'b0;
						if (st_q == `ST_DEV) begin
							// busy or foreign type: stay released until next start
							if (sr_q[`TYPE_HI:`TYPE_LO] != DEV_TYPE || BUSY) begin
								st_q     <= `ST_IDLE;
								SDA_OE_N <= 1'b1;
							end else begin
								bank_q  <= sr_q[`BANK_HI:`BANK_LO];
								rmode_q <= sr_q[`RW_BIT];
								flush_q <= sr_q[`RW_BIT];
								nxt_q   <= sr_q[`RW_BIT] ? `ST_TX : `ST_WORD;
							end
						end else if (st_q == `ST_WORD) begin
							addr_q <= {bank_q, sr_q};
							nxt_q  <= `ST_DATA;
						end else begin
							pwe_q  <= 1'b1;
							pwa_q  <= addr_q[`PAGE_AW-1:0];
							pwd_q  <= sr_q;
							mask_q <= mask_q | (16'h0001 << addr_q[`PAGE_AW-1:0]);
							// only the low four bits count, so the page wraps
							addr_q[`PAGE_AW-1:0] <= addr_q[`PAGE_AW-1:0] + 4'h1;
							nxt_q  <= `ST_DATA;
						end
					end
				end
				`ST_ACK, `ST_RACK: begin
					if (scl_rise && st_q == `ST_RACK) begin
						mack_q <= ~sda_s_q;
					end else if (scl_fall) begin
						cnt_q    <= 4'h0;
						SDA_OE_N <= 1'b1;
						if (load_c) begin
							// current address or next sequential byte
							tx_q     <= out_data;
							SDA_OE_N <= out_data[7];
							addr_q   <= addr_q + 11'h001;
							st_q     <= `ST_TX;
						end else if (st_q == `ST_RACK) begin
							st_q    <= `ST_IDLE;
							rmode_q <= 1'b0;
						end else begin
							st_q <= nxt_q;
						end
					end
				end
				`ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `TX_LAST) begin
							SDA_OE_N <= 1'b1;
							mack_q   <= 1'b0;
							st_q     <= `ST_RACK;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							SDA_OE_N <= tx_q[6];
							cnt_q    <= cnt_q + 4'h1;
						end
					end
				end
				default: begin
					SDA_OE_N <= 1'b1;
				end
				endcase
			end
		end
	end

	// read prefetch into the two-entry buffer
	always @(posedge MCLK) begin
		if (!RSTN) begin
			f0_q   <= 8'h00;
			f1_q   <= 8'h00;
			fcnt_q <= 2'h0;
			infl_q <= 1'b0;
			pf_q   <= 11'h000;
		end else if (flush_q) begin
			fcnt_q <= 2'h0;
			infl_q <= 1'b0;
			pf_q   <= addr_q;
		end else begin
			infl_q <= fetch_c;
			if (fetch_c) begin
				pf_q <= pf_q + 11'h001;
			end
			if (pop_c) begin
				f0_q <= (infl_q && fcnt_q == 2'h1) ? arr_rd : f1_q;
			end else if (infl_q && fcnt_q == 2'h0) begin
				f0_q <= arr_rd;
			end
			if (infl_q && !pop_c && fcnt_q == 2'h1) begin
				f1_q <= arr_rd;
			end else if (infl_q && pop_c && fcnt_q == 2'h2) begin
				f1_q <= arr_rd;
			end
			fcnt_q <= fcnt_q + {1'b0, infl_q} - {1'b0, pop_c};
		end
	end

	// self-timed write: copy page buffer into the array, hold busy for the cycle time
	always @(posedge MCLK) begin
		if (!RSTN) begin
			BUSY     <= 1'b0;
			tmr_q    <= {TW{1'b0}};
			cidx_q   <= 5'h00;
			cidx_d_q <= 4'h0;
			cv_q     <= 1'b0;
			wmask_q  <= 16'h0000;
		end else if (wstart_q) begin
			BUSY    <= 1'b1;
			tmr_q   <= {TW{1'b0}};
			cidx_q  <= 5'h00;
			cv_q    <= 1'b0;
			wmask_q <= mask_q;
		end else if (BUSY) begin
			tmr_q    <= tmr_q + {{(TW-1){1'b0}}, 1'b1};
			cv_q     <= (cidx_q < `PAGE_SLOTS);
			cidx_d_q <= cidx_q[`PAGE_AW-1:0];
			if (cidx_q < `PAGE_SLOTS) begin
				cidx_q <= cidx_q + 5'h01;
			end
			if (tmr_q == WC_LAST) begin
				BUSY <= 1'b0;
			end
		end else begin
			cv_q <= 1'b0;
		end
	end

	wire                   arr_we   = cv_q & wmask_q[cidx_d_q];
	wire [`ARR_AW-1:0]     arr_addr = BUSY ? {addr_q[`ARR_AW-1:`PAGE_AW], cidx_d_q} : pf_q;
	wire [`PAGE_AW-1:0]    page_a   = BUSY ? cidx_q[`PAGE_AW-1:0] : pwa_q;

	eeprom_mem #(
		.AW (`PAGE_AW),
		.DW (`BYTE_W)
	) page_buf (
		.clk     (MCLK),
		.rstn    (RSTN),
		.we      (pwe_q),
		.addr    (page_a),
		.wdata   (pwd_q),
		.rdata_q (page_rd)
	);

	eeprom_mem #(
		.AW (`ARR_AW),
		.DW (`BYTE_W)
	) array (
		.clk     (MCLK),
		.rstn    (RSTN),
		.we      (arr_we),
		.addr    (arr_addr),
		.wdata   (page_rd),
		.rdata_q (arr_rd)
	);
endmodule

/* File: rtl/eeprom_slave_regs.vh */
// constants of the two-wire serial memory slave
// Functional notes
// - data changes only while clock low; data edges with clock high mean start or stop
// - start is data falling with clock high; nothing answered before a start
// - stop is data rising with clock high; ends every transfer, returns to standby
// - after eight bits transmitter releases; receiver pulls data low in ninth clock
// - device acknowledges a start followed by a slave address of matching type
// - selected for writing, device acknowledges every following byte
// - read mode sends eight bits, samples acknowledge, continues when acknowledged
// - no acknowledge after read byte stops sending; master then issues stop
// - upper four address bits are the device type; mismatch gets no answer
// - next three address bits select bank, the top three array address bits
// - last address bit one means read, zero means write
// - write sends word address then data byte, both acknowledged, reaching 2048 bytes
// - stop after write data starts the self-timed internal write
// - during internal write inputs are ignored, no request is answered
// - page write takes up to sixteen data bytes, each acknowledged
// - page write increments low four address bits only; overflow wraps in page
// - polling with write address gets no acknowledge until write cycle ends
// - address counter holds last accessed location plus one for next read
// - current address read acknowledges then sends byte at counter address
// - random read is dummy write of address, repeated start, read address
// - sequential read counter advances all bits, wrapping 2047 to zero
`ifndef EEPROM_SLAVE_REGS_VH
`define EEPROM_SLAVE_REGS_VH
`define ARR_AW      11
`define PAGE_AW     4
`define BYTE_W      8
`define BYTE_BITS   4'h8
`define TX_LAST     4'h7
`define TYPE_HI     7
`define TYPE_LO     4
`define BANK_HI     3
`define BANK_LO     1
`define RW_BIT      0
`define PAGE_SLOTS  5'h10
`define T_WR_US     5000
`define MCLK_KHZ    10000
`define ST_IDLE     3'h0
`define ST_DEV      3'h1
`define ST_WORD     3'h2
`define ST_DATA     3'h3
`define ST_ACK      3'h4
`define ST_TX       3'h5
`define ST_RACK     3'h6
`endif

/* File: verification/eeprom_slave_chk.sv */
// pin assertions for the serial memory slave
`timescale 1ns/1ps
module eeprom_slave_chk #(
	parameter WRITE_CYCLES = 200
) (
	input wire MCLK,
	input wire RSTN,
	input wire SCL,
	input wire SDA_I,
	input wire SDA_O,
	input wire SDA_OE_N,
	input wire BUSY
);
	reg [15:0] cnt_q;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	always @(posedge MCLK)
		cnt_q <= (RSTN && BUSY) ? cnt_q + 16'h0001 : 16'h0000;
	chk_open_drain_low: assert property (SDA_O == 1'b0)
		else $error("data output not low");
	chk_reset_idle: assert property ($rose(RSTN) |-> SDA_OE_N && !BUSY)
		else $error("not idle after reset");
	chk_change_clock_low: assert property ($changed(SDA_OE_N) |-> !SCL)
		else $error("data changed with clock high");
	chk_busy_length: assert property ($fell(BUSY) |->
		cnt_q >= WRITE_CYCLES - 2 && cnt_q <= WRITE_CYCLES + 2)
		else $error("write cycle length wrong");
	chk_busy_quiet: assert property (BUSY |-> SDA_OE_N)
		else $error("answered while busy");
	chk_busy_after_stop: assert property ($rose(BUSY) |-> SCL && SDA_I)
		else $error("write began outside idle bus");
	chk_start_address_quiet: assert property (SCL && $fell(SDA_I) |-> ##1 SDA_OE_N[*8])
		else $error("drove during address");
	chk_bit_stands: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N[*6])
		else $error("low bit too short");
endmodule

/* File: verification/test_eeprom_slave.sv */
// bench for the two-wire serial memory slave
`timescale 1ns/1ps
module test_eeprom_slave;
	reg        MCLK = 1'b0;
	reg        RSTN = 1'b0;
	wire       SCL;
	wire       SDA;
	wire       SDA_O;
	wire       SDA_OE_N;
	wire       BUSY;
	wire       m_sda;
	integer    fails = 0;
	integer    total_checks = 0;
	integer    i;
	reg        ack;
	reg [7:0]  d;
	always #50 MCLK = ~MCLK;
	assign SDA = (SDA_OE_N === 1'b0) ? 1'b0 : m_sda;
	// type code 4'h5 is arbitrary
	eeprom_slave #(.DEV_TYPE(4'h5), .WRITE_CYCLES(200)) u_dut (.MCLK(MCLK), .RSTN(RSTN),
		.SCL(SCL), .SDA_I(SDA), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY));
	two_wire_master u_mst (.clk(MCLK), .sda_in(SDA), .scl(SCL), .sda(m_sda));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("MISMATCH %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task dev(input [10:0] a, input rw, input exp);
		begin
			u_mst.wbyte({4'h5, a[10:8], rw}, ack);
			chk({7'h00, ack}, {7'h00, exp});
		end
	endtask
	task poll;
		integer n;
		begin
			n = 0;
			ack = 1'b0;
			while (!ack) begin
				if (n == 20) begin
					fails = fails + 1;
					$display("MISMATCH %0t poll timeout", $time);
					test_done;
				end
				n = n + 1;
				u_mst.start;
				u_mst.wbyte(8'h50, ack);
				u_mst.stop;
			end
			chk({7'h00, n > 1}, 8'h01);
		end
	endtask
	task seek(input [10:0] a);
		begin
			u_mst.start;
			dev(a, 1'b0, 1'b1);
			u_mst.wbyte(a[7:0], ack);
			chk({7'h00, ack}, 8'h01);
			u_mst.start;
			dev(a, 1'b1, 1'b1);
		end
	endtask
	task wr(input [10:0] a, input [7:0] v);
		begin
			u_mst.start;
			dev(a, 1'b0, 1'b1);
			u_mst.wbyte(a[7:0], ack);
			chk({7'h00, ack}, 8'h01);
			u_mst.wbyte(v, ack);
			chk({7'h00, ack}, 8'h01);
			u_mst.stop;
			repeat (8) @(posedge MCLK);
			chk({7'h00, BUSY}, 8'h01);
			poll;
		end
	endtask
	task t_byte;
		begin
			wr(11'h53C, 8'hC3);
			wr(11'h13C, 8'h3C);
			seek(11'h53C);
			u_mst.rbyte(1'b0, d);
			chk(d, 8'hC3);
			u_mst.stop;
			$display("byte test done");
		end
	endtask
	task t_page;
		begin
			u_mst.start;
			dev(11'h2A0, 1'b0, 1'b1);
			u_mst.wbyte(8'hA0, ack);
			for (i = 0; i < 17; i = i + 1) begin
				u_mst.wbyte(8'h10 + i[7:0], ack);
				chk({7'h00, ack}, 8'h01);
			end
			u_mst.stop;
			poll;
			seek(11'h2A0);
			for (i = 0; i < 16; i = i + 1) begin
				u_mst.rbyte(i < 15, d);
				chk(d, (i == 0) ? 8'h20 : 8'h10 + i[7:0]);
			end
			u_mst.stop;
			seek(11'h2AE);
			u_mst.rbyte(1'b0, d);
			u_mst.stop;
			u_mst.start;
			dev(11'h000, 1'b1, 1'b1);
			u_mst.rbyte(1'b0, d);
			chk(d, 8'h1F);
			u_mst.stop;
			$display("page test done");
		end
	endtask
	task t_wrap;
		begin
			wr(11'h7FF, 8'h5A);
			wr(11'h000, 8'hA5);
			seek(11'h7FF);
			u_mst.rbyte(1'b1, d);
			chk(d, 8'h5A);
			u_mst.rbyte(1'b0, d);
			chk(d, 8'hA5);
			repeat (4) @(posedge MCLK);
			chk({7'h00, SDA_OE_N}, 8'h01);
			u_mst.stop;
			$display("wrap test done");
		end
	endtask
	task t_foreign;
		begin
			u_mst.start;
			u_mst.wbyte(8'h30, ack);
			chk({7'h00, ack}, 8'h00);
			u_mst.wbyte(8'h00, ack);
			chk({7'h00, ack}, 8'h00);
			u_mst.stop;
			$display("foreign test done");
		end
	endtask
	initial begin
		repeat (8) @(posedge MCLK);
		RSTN <= 1'b1;
		repeat (4) @(posedge MCLK);
		t_byte;
		t_page;
		t_wrap;
		t_foreign;
		test_done;
	end
endmodule
bind eeprom_slave eeprom_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.MCLK(MCLK),
	.RSTN(RSTN), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY));

/* File: verification/two_wire_master.sv */
// two-wire bus master model; one bit is eight system clocks
`timescale 1ns/1ps
module two_wire_master (
	input  wire clk,
	input  wire sda_in,
	output reg  scl,
	output reg  sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// clock low five cycles first so a late slave release cannot fake a stop
	task start;
		begin
			@(posedge clk) sda <= 1'b1;
			repeat (4) @(posedge clk);
			scl <= 1'b1;
			repeat (2) @(posedge clk);
			sda <= 1'b0;
			repeat (2) @(posedge clk);
			scl <= 1'b0;
		end
	endtask
	task stop;
		begin
			@(posedge clk) sda <= 1'b0;
			repeat (4) @(posedge clk);
			scl <= 1'b1;
			repeat (2) @(posedge clk);
			sda <= 1'b1;
			repeat (2) @(posedge clk);
		end
	endtask
	task bit_io(input b, output s);
		begin
			@(posedge clk) sda <= b;
			repeat (3) @(posedge clk);
			scl <= 1'b1;
			repeat (4) @(posedge clk);
			s = sda_in;
			scl <= 1'b0;
		end
	endtask
	task wbyte(input [7:0] d, output ack);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bit_io(d[i], s);
			bit_io(1'b1, s);
			ack = !s;
		end
	endtask
	task rbyte(input ack, output [7:0] d);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bit_io(1'b1, s);
				d[i] = s;
			end
			bit_io(!ack, s);
		end
	endtask
endmodule
